// [output_clock_sync.sv]
// Output clock generator, sample demultiplexer and multi-device synchroniser.
// Assumes samples arrive one pair per clk_sys cycle; pins other than the clock reset are synchronous.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module output_clock_sync #(
    parameter int DELAY_DEPTH = output_clock_sync_pkg::OUTPUT_DELAY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [output_clock_sync_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [output_clock_sync_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [output_clock_sync_pkg::DATA_W-1:0] reg_rdata,
    input wire output_clock_sync_pkg::sample_s i_sample,
    input wire output_clock_sync_pkg::sample_s q_sample,
    input wire logic q_chan_power_down,
    input wire logic out_clock_reset_in,
    input wire logic out_clock_phase_sel,
    input wire logic sync_ref_clock_in,
    output logic i_chan_out_clock,
    output logic q_chan_out_clock,
    output logic [output_clock_sync_pkg::SAMPLE_W-1:0] i_data_bus,
    output logic [output_clock_sync_pkg::SAMPLE_W-1:0] q_data_bus,
    output logic [output_clock_sync_pkg::SAMPLE_W-1:0] i_delayed_data_bus,
    output logic [output_clock_sync_pkg::SAMPLE_W-1:0] q_delayed_data_bus,
    output logic i_delayed_oe_n,
    output logic q_delayed_oe_n,
    output logic i_over_range,
    output logic q_over_range,
    output logic sync_ref_clock_out_a,
    output logic sync_ref_clock_out_b
);
    import output_clock_sync_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;
    logic [1:0] sel_phase_r;
    logic demux;
    logic ocr_en;
    logic [TAD_W-1:0] tad;
    logic ocr_meta_r;
    logic ocr_sync_r;
    resync_e resync_state_r;
    logic [2:0] cnt_r;
    logic [2:0] target_r;
    logic first_done_r;
    logic [1:0] phase_r;
    logic toggle_r;
    logic ref_r;
    logic ref_prev_r;
    logic ref_rise;
    logic held;
    sample_s i_first_r;
    sample_s q_first_r;
    lane_s lane_nxt;
    lane_s lane_hold_r;
    lane_s dly_r [DELAY_DEPTH];
    lane_s tap;

    assign demux = ctrl_r[CTRL_DEMUX_BIT];
    assign ocr_en = ctrl_r[CTRL_OCR_EN_BIT];
    assign tad = ctrl_r[CTRL_TAD_LSB +: TAD_W];
    // Demux clock stays high from assertion until the synchronising edge, not just until release
    assign held = (resync_state_r != RS_IDLE) && demux;
    assign ref_rise = ref_r && !ref_prev_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            sel_phase_r <= SEL_PHASE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CTRL) begin
                ctrl_r <= reg_wdata[CTRL_W-1:0];
            end else if (reg_addr == ADDR_SEL_PHASE) begin
                sel_phase_r <= reg_wdata[SEL_PHASE_LSB +: 2];
            end
        end
    end

    // Register reads, answered the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_CTRL) begin
                reg_rdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
            end else if (reg_addr == ADDR_SEL_PHASE) begin
                reg_rdata <= {{(DATA_W-SEL_PHASE_LSB-2){1'b0}}, sel_phase_r, {SEL_PHASE_LSB{1'b0}}};
            end else if (reg_addr == ADDR_STATUS) begin
                reg_rdata <= {{(DATA_W-ST_PHASE_LSB-2){1'b0}}, phase_r, held, first_done_r,
                              resync_state_r != RS_IDLE};
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // Two-stage synchroniser; the reset pin may move at any time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ocr_meta_r <= 1'b0;
            ocr_sync_r <= 1'b0;
        end else begin
            ocr_meta_r <= out_clock_reset_in;
            ocr_sync_r <= ocr_meta_r;
        end
    end

    // Release sequencer: count from the first edge that sees the release
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            resync_state_r <= RS_IDLE;
            cnt_r <= 3'h0;
            target_r <= RESYNC_DLY_0;
            first_done_r <= 1'b0;
        end else if (!ocr_en) begin
            resync_state_r <= RS_IDLE;
            cnt_r <= 3'h0;
        end else begin
            case (resync_state_r)
                RS_IDLE: begin
                    if (ocr_sync_r) begin
                        resync_state_r <= RS_HELD;
                    end
                end
                RS_HELD: begin
                    if (!ocr_sync_r) begin
                        resync_state_r <= RS_COUNT;
                        cnt_r <= 3'h1;
                        target_r <= out_clock_phase_sel ? RESYNC_DLY_90 : RESYNC_DLY_0;
                    end
                end
                RS_COUNT: begin
                    if (ocr_sync_r) begin
                        resync_state_r <= RS_HELD;
                    end else if (cnt_r == target_r) begin
                        resync_state_r <= RS_IDLE;
                        first_done_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 3'h1;
                    end
                end
                default: begin
                    resync_state_r <= RS_IDLE;
                end
            endcase
        end
    end

    // Reference clock from a primary, taken as a synchronous pin
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ref_r <= 1'b0;
            ref_prev_r <= 1'b0;
        end else begin
            ref_r <= sync_ref_clock_in;
            ref_prev_r <= ref_r;
        end
    end

    // Demux clock phase: held, reloaded at the synchronising edge, or pulled to the reference.
    // The first release after power-up keeps the free-running phase, so a dummy pulse is needed.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= 2'h0;
        end else if (resync_state_r == RS_COUNT && !ocr_sync_r && cnt_r == target_r && first_done_r) begin
            // Load wins over the hold: the synchronising edge falls inside the held window
            phase_r <= sel_phase_r;
        end else if (held) begin
            phase_r <= phase_r;
        end else if (ctrl_r[CTRL_CONT_SYNC_BIT] && ctrl_r[CTRL_SECONDARY_BIT] && ref_rise) begin
            phase_r <= PHASE_AT_REF;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Non-demux clock toggles every sample, regardless of the clock reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            toggle_r <= 1'b0;
        end else begin
            toggle_r <= !toggle_r;
        end
    end

    // First sample of each demux pair waits here for its partner
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            i_first_r <= '0;
            q_first_r <= '0;
        end else if (!phase_r[0]) begin
            i_first_r <= i_sample;
            q_first_r <= q_sample;
        end
    end

    // Sample data holds between demux pair updates
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lane_hold_r <= '0;
        end else begin
            lane_hold_r <= lane_nxt;
        end
    end

    always_comb begin
        lane_nxt = lane_hold_r;
        if (demux) begin
            lane_nxt.clk = held ? 1'b1 : !phase_r[1];
            lane_nxt.delayed_en = 1'b1;
            // Data freeze with the clock so a held clock never frames a torn pair
            if (phase_r[0] && !held) begin
                // Two buses at half rate keep the aggregate rate
                lane_nxt.id = i_first_r;
                lane_nxt.qd = q_first_r;
                lane_nxt.i = i_sample;
                lane_nxt.q = q_sample;
            end
        end else begin
            lane_nxt.clk = toggle_r;
            lane_nxt.delayed_en = 1'b0;
            lane_nxt.i = i_sample;
            lane_nxt.q = q_sample;
            lane_nxt.id = '0;
            lane_nxt.qd = '0;
        end
        if (q_chan_power_down) begin
            lane_nxt.q = '0;
            lane_nxt.qd = '0;
        end
    end

    // Output delay line; aperture adjust taps it earlier
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int k = 0; k < DELAY_DEPTH; k++) begin
                dly_r[k] <= '0;
            end
        end else begin
            dly_r[0] <= lane_nxt;
            for (int k = 1; k < DELAY_DEPTH; k++) begin
                dly_r[k] <= dly_r[k-1];
            end
        end
    end

    always_comb begin
        if (int'(tad) < DELAY_DEPTH) begin
            tap = dly_r[DELAY_DEPTH - 1 - int'(tad)];
        end else begin
            tap = dly_r[0];
        end
    end

    // Every pin comes straight from a flip-flop; I and Q clocks share one source
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            i_chan_out_clock <= 1'b0;
            q_chan_out_clock <= 1'b0;
            i_data_bus <= '0;
            q_data_bus <= '0;
            i_delayed_data_bus <= '0;
            q_delayed_data_bus <= '0;
            i_delayed_oe_n <= 1'b1;
            q_delayed_oe_n <= 1'b1;
            i_over_range <= 1'b0;
            q_over_range <= 1'b0;
        end else begin
            i_chan_out_clock <= tap.clk;
            q_chan_out_clock <= tap.clk && !q_chan_power_down;
            i_data_bus <= tap.i.data;
            q_data_bus <= tap.q.data;
            i_delayed_data_bus <= tap.id.data;
            q_delayed_data_bus <= tap.qd.data;
            i_delayed_oe_n <= !tap.delayed_en;
            q_delayed_oe_n <= !tap.delayed_en;
            i_over_range <= tap.i.over || tap.id.over;
            q_over_range <= tap.q.over || tap.qd.over;
        end
    end

    // Undelayed reference for secondaries, on two pins for a binary tree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_ref_clock_out_a <= 1'b0;
            sync_ref_clock_out_b <= 1'b0;
        end else begin
            sync_ref_clock_out_a <= lane_nxt.clk;
            sync_ref_clock_out_b <= lane_nxt.clk;
        end
    end

    sequence s_release;
        (resync_state_r == RS_HELD) ##1 (resync_state_r == RS_COUNT && cnt_r == 3'h1);
    endsequence

    AST_RELEASE_90: assert property (s_release ##0 (target_r == RESYNC_DLY_90)
        |-> ##3 (resync_state_r != RS_IDLE) ##1 (resync_state_r != RS_COUNT))
        else $error("sync edge not four cycles after release");

    AST_RELEASE_0: assert property (s_release ##0 (target_r == RESYNC_DLY_0)
        |-> ##4 (resync_state_r != RS_IDLE) ##1 (resync_state_r != RS_COUNT))
        else $error("sync edge not five cycles after release");

    AST_HOLD_HIGH: assert property (held |-> lane_nxt.clk ##1 dly_r[0].clk)
        else $error("output clock not held high during reset in demux");

    AST_NONDEMUX_TOGGLE: assert property ((!demux && $past(rst_n, 2))[*3] |-> dly_r[0].clk != $past(dly_r[0].clk))
        else $error("non-demux clock stopped toggling");

    AST_TRISTATE: assert property ((!demux)[*2] ##1 (!demux)
        |-> ##DELAY_DEPTH (i_delayed_oe_n && q_delayed_oe_n))
        else $error("delayed buses driven in non-demux mode");

    AST_SYNC_IN: assert property ($rose(out_clock_reset_in) ##1 out_clock_reset_in |-> ##1 ocr_sync_r)
        else $error("clock reset not synchronised in two cycles");

    AST_OCR_OFF: assert property (!ocr_en |=> resync_state_r == RS_IDLE)
        else $error("clock reset acted while disabled");

    AST_IQ_PHASE: assert property (!q_chan_power_down ##1 !q_chan_power_down
        |-> i_chan_out_clock == q_chan_out_clock)
        else $error("I and Q output clocks differ");

    AST_REALIGN: assert property (ctrl_r[CTRL_CONT_SYNC_BIT] && ctrl_r[CTRL_SECONDARY_BIT] && ref_rise
        && resync_state_r == RS_IDLE |=> phase_r == PHASE_AT_REF)
        else $error("secondary not realigned to reference");

    AST_OUT_DELAY: assert property (tad == '0 && $past(tad) == '0 && $past(rst_n, DELAY_DEPTH)
        |-> i_chan_out_clock == $past(dly_r[0].clk, DELAY_DEPTH))
        else $error("output clock delay differs from fixed delay");

    AST_RATE: assert property ((!demux && $past(rst_n))[*2] |-> dly_r[0].i.data == $past(i_sample.data))
        else $error("sample lost in non-demux mode");
endmodule

// [output_clock_sync_pkg.sv]
// Constants, register map and carrier types for the output clock and data synchroniser.
// Assumes one sampling-clock domain; software reaches the registers over a plain strobe port.
package output_clock_sync_pkg;
    localparam int SAMPLE_W = 12;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_SEL_PHASE = 6'h0e;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SEL_PHASE = {IDX_SEL_PHASE, 2'h0};
    // Control fields
    localparam int CTRL_DEMUX_BIT = 0;
    localparam int CTRL_OCR_EN_BIT = 1;
    localparam int CTRL_CONT_SYNC_BIT = 2;
    localparam int CTRL_SECONDARY_BIT = 3;
    localparam int CTRL_TAD_LSB = 4;
    localparam int TAD_W = 2;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    // Select-phase field
    localparam int SEL_PHASE_LSB = 3;
    localparam logic [1:0] SEL_PHASE_RESET = 2'h0;
    // Status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_FIRST_DONE_BIT = 1;
    localparam int ST_HELD_BIT = 2;
    localparam int ST_PHASE_LSB = 3;
    // Release latency to the synchronising edge
    localparam logic [2:0] RESYNC_DLY_90 = 3'h4;
    localparam logic [2:0] RESYNC_DLY_0 = 3'h5;
    // Phase the secondary adopts one cycle after it sees a reference rising edge
    localparam logic [1:0] PHASE_AT_REF = 2'h1;
    // Fixed output delay
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OUTPUT_DELAY_NS = 15;
    localparam int OUTPUT_DELAY_CYC = (OUTPUT_DELAY_NS * 1000) / CLK_PERIOD_PS;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic over;
    } sample_s;

    typedef struct packed {
        logic clk;
        logic delayed_en;
        sample_s i;
        sample_s q;
        sample_s id;
        sample_s qd;
    } lane_s;

    typedef enum {RS_IDLE, RS_HELD, RS_COUNT} resync_e;
endpackage

// [sync_ref_source.sv]
// Model of a primary converter that sources the reference clock for this secondary.
// Assumes the same sampling clock as the block under test; slip stalls it for one cycle.
`timescale 1ns/10ps
module sync_ref_source (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic slip,
    output logic ref_clk
);
    logic [1:0] phase_r;

    // Same four-phase rate as the demux output clock, so secondaries lock to it
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= 2'h0;
        end else if (!slip) begin
            phase_r <= phase_r + 2'h1;
        end
    end
    // A stalled cycle models an upset the secondary has to recover
    always @(posedge clk_sys) begin
        ref_clk <= rst_n & phase_r[1];
    end
endmodule

// [tb_top.sv]
// Self-checking bench for output_clock_sync: registers, data paths, clock reset, reference lock.
// Assumes the design package is compiled first and sync_ref_source plays the primary.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module tb_top;
    import output_clock_sync_pkg::*;
    localparam int DEPTH = 2;
    localparam int LAT = DEPTH + 1;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata, er;
    sample_s i_sample = '0;
    sample_s q_sample = '0;
    sample_s ni, nq;
    logic q_chan_power_down = 1'b0;
    logic out_clock_reset_in = 1'b0;
    logic out_clock_phase_sel = 1'b1;
    logic sync_ref_clock_in, sync_ref_clock_out_a, sync_ref_clock_out_b;
    logic slip = 1'b0;
    logic i_chan_out_clock, q_chan_out_clock, i_delayed_oe_n, q_delayed_oe_n, i_over_range, q_over_range;
    logic [SAMPLE_W-1:0] i_data_bus, q_data_bus, i_delayed_data_bus, q_delayed_data_bus;
    int seed = 72465;
    int n_mismatch = 0;
    int tests_run = 0;
    int d90, d0, k1, k2, tog, chg;
    logic ramp = 1'b0;
    logic chk_nd = 1'b0;
    logic rd_seen, prev_clk;
    logic rd_prev = 1'b0;
    logic [DATA_W-1:0] rq[$];
    logic [25:0] dq[$];
    logic [25:0] ed;

    output_clock_sync #(.DELAY_DEPTH(DEPTH)) i_output_clock_sync (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .i_sample(i_sample),
        .q_sample(q_sample), .q_chan_power_down(q_chan_power_down),
        .out_clock_reset_in(out_clock_reset_in), .out_clock_phase_sel(out_clock_phase_sel),
        .sync_ref_clock_in(sync_ref_clock_in), .i_chan_out_clock(i_chan_out_clock),
        .q_chan_out_clock(q_chan_out_clock), .i_data_bus(i_data_bus), .q_data_bus(q_data_bus),
        .i_delayed_data_bus(i_delayed_data_bus), .q_delayed_data_bus(q_delayed_data_bus),
        .i_delayed_oe_n(i_delayed_oe_n), .q_delayed_oe_n(q_delayed_oe_n), .i_over_range(i_over_range),
        .q_over_range(q_over_range), .sync_ref_clock_out_a(sync_ref_clock_out_a),
        .sync_ref_clock_out_b(sync_ref_clock_out_b)
    );
    sync_ref_source i_sync_ref_source (.clk_sys(clk_sys), .rst_n(rst_n), .slip(slip), .ref_clk(sync_ref_clock_in));

    always #2.5 clk_sys = ~clk_sys;

    // Sample source: random words, or a ramp so demux pairs can be checked without alignment
    always @(posedge clk_sys) begin
        if (ramp) begin
            ni = {i_sample.data + 12'h001, 1'b0};
            nq = {q_sample.data + 12'h001, 1'b0};
        end else begin
            ni = sample_s'(13'($random(seed)));
            nq = sample_s'(13'($random(seed)));
        end
        i_sample <= ni;
        q_sample <= nq;
        if (chk_nd) dq.push_back({ni, nq});
    end

    // Outputs are read 1 ns after the edge so the design's updates have landed
    always @(posedge clk_sys) begin
        rd_seen = reg_rd;
        prev_clk = i_chan_out_clock;
        #1;
        if (rd_seen) begin
            er = rq.pop_front();
            `CHK("reg_rdata", er, reg_rdata)
        end else if (rd_prev) `CHK("reg_rdata idle", 32'h0, reg_rdata)
        rd_prev = rd_seen;
        if (chk_nd && dq.size() > LAT) begin
            ed = dq.pop_front();
            `CHK("i_data_bus", ed[25:14], i_data_bus)
            `CHK("i_over_range", ed[13], i_over_range)
            `CHK("q_data_bus", q_chan_power_down ? 12'h000 : ed[12:1], q_data_bus)
            `CHK("q_over_range", q_chan_power_down ? 1'b0 : ed[0], q_over_range)
            `CHK("i clock toggle", ~prev_clk, i_chan_out_clock)
            `CHK("q clock", q_chan_power_down ? 1'b0 : i_chan_out_clock, q_chan_out_clock)
            `CHK("delayed oe", 2'h3, {i_delayed_oe_n, q_delayed_oe_n})
            `CHK("delayed buses", 24'h0, {i_delayed_data_bus, q_delayed_data_bus})
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask

    task automatic nd_check(input int n);
        @(posedge clk_sys);
        dq.delete();
        chk_nd <= 1'b1;
        repeat (n) @(posedge clk_sys);
        chk_nd <= 1'b0;
    endtask

    task automatic demux_watch(input int n);
        logic pc;
        logic [SAMPLE_W-1:0] pd;
        tog = 0;
        chg = 0;
        @(posedge clk_sys);
        #1;
        pc = i_chan_out_clock;
        pd = i_data_bus;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (i_chan_out_clock !== pc) tog++;
            if (i_data_bus !== pd) chg++;
            `CHK("demux pair", i_delayed_data_bus + 12'h001, i_data_bus)
            `CHK("q clock demux", i_chan_out_clock, q_chan_out_clock)
            `CHK("delayed oe demux", 1'b0, i_delayed_oe_n)
            pc = i_chan_out_clock;
            pd = i_data_bus;
        end
    endtask

    task automatic until_fall(output int n);
        n = 0;
        @(posedge clk_sys);
        #1;
        while (i_chan_out_clock !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    // Asserted off the clock grid, released at a fixed offset so latencies compare
    task automatic pulse(input logic ph, output int n);
        @(posedge clk_sys);
        out_clock_phase_sel <= ph;
        #1.3 out_clock_reset_in = 1'b1;
        // Watching starts well after assertion so a narrow clock glitch is tolerated
        repeat (12) @(posedge clk_sys);
        demux_watch(8);
        `CHK("held data", 0, chg)
        `CHK("held clock edges", 0, tog)
        `CHK("held clock level", 1'b1, i_chan_out_clock)
        @(posedge clk_sys);
        #2 out_clock_reset_in = 1'b0;
        until_fall(n);
        `CHK("clock resumes", 1'b1, n < 40)
        repeat (20) @(posedge clk_sys);
    endtask

    task automatic ref_fall(output int n);
        @(posedge sync_ref_clock_in);
        until_fall(n);
    endtask

    task automatic results();
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_SEL_PHASE, 32'h0);
        rd(8'h08, 32'h0);
        wr(8'h08, 32'hffffffff);
        rd(8'h08, 32'h0);
        wr(ADDR_CTRL, 32'hffffffff);
        rd(ADDR_CTRL, 32'h3f);
        wr(ADDR_SEL_PHASE, 32'hffffffff);
        rd(ADDR_SEL_PHASE, 32'h18);
        wr(ADDR_SEL_PHASE, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        repeat (10) @(posedge clk_sys);
        nd_check(30);
        q_chan_power_down <= 1'b1;
        repeat (10) @(posedge clk_sys);
        nd_check(20);
        q_chan_power_down <= 1'b0;
        wr(ADDR_CTRL, 32'h2);
        #1.3 out_clock_reset_in = 1'b1;
        nd_check(20);
        #1.7 out_clock_reset_in = 1'b0;
        ramp <= 1'b1;
        wr(ADDR_CTRL, 32'h1);
        // Ignored while the clock reset is disabled
        #1.3 out_clock_reset_in = 1'b1;
        repeat (10) @(posedge clk_sys);
        demux_watch(16);
        `CHK("demux clock edges", 8, tog)
        `CHK("demux updates", 8, chg)
        #1 out_clock_reset_in = 1'b0;
        wr(ADDR_CTRL, 32'h3);
        pulse(1'b1, d90);
        pulse(1'b1, d90);
        pulse(1'b0, d0);
        `CHK("sync latency step", d90 + 1, d0)
        pulse(1'b1, k1);
        `CHK("repeatable release", d90, k1)
        wr(ADDR_CTRL, 32'hd);
        repeat (16) @(posedge clk_sys);
        ref_fall(k1);
        ref_fall(k2);
        `CHK("ref offset steady", k1, k2)
        @(posedge clk_sys);
        slip <= 1'b1;
        @(posedge clk_sys);
        slip <= 1'b0;
        repeat (8) @(posedge clk_sys);
        ref_fall(k2);
        `CHK("ref offset after slip", k1, k2)
        results();
    end
endmodule
